// ---- logic/iqr_defines.vh ----
// Operation
// - Six-byte block: opcode 12h, lun byte1[7:5], select bit byte1[0], page, length, control
// - Pending unit attention is kept; inquiry data is still returned
// - Check condition only when the requested data cannot be returned
// - Data returned while medium not ready; medium fields read as spaces
// - Inquiry data change raises unit attention, target conditions changed
// - Select clear returns standard data; set returns the named page
// - Select clear with nonzero page code: check condition, 05h/24h
// - Unimplemented page requested: check condition, 05h/24h
// - Exactly two pages: supported list 00h and serial number 80h
// - Page byte 0 is 00h for lun zero, 7Fh otherwise
// - Supported list: code 00h, reserved, length, then 00h and 80h
// - Page length byte reports the full length even when truncated
// - Serial page: code 80h, reserved, length 08h, serial in bytes 4-11
// - Serial least significant character in byte 11; spaces if unavailable
// - Standard inquiry data is 36 bytes long
`ifndef IQR_DEFINES_VH
`define IQR_DEFINES_VH

`define IQR_OFF_CTRL      8'h00
`define IQR_OFF_CDB_LO    8'h04
`define IQR_OFF_CDB_HI    8'h08
`define IQR_OFF_STATUS    8'h0c
`define IQR_OFF_IRQ_STAT  8'h10
`define IQR_OFF_IRQ_MASK  8'h14
`define IQR_OFF_XFER_LEN  8'h18

`define IQR_CTRL_START    0
`define IQR_CTRL_UA_CLR   1

`define IQR_IRQ_DONE      0
`define IQR_IRQ_CHECK     1
`define IQR_IRQ_UA        2
`define IQR_IRQ_W         3

`define IQR_OPCODE        8'h12
`define IQR_PAGE_LIST     8'h00
`define IQR_PAGE_SERIAL   8'h80
`define IQR_LEN_STD       8'h24
`define IQR_LEN_LIST      8'h06
`define IQR_LEN_SERIAL    8'h0c
`define IQR_PLEN_LIST     8'h02
`define IQR_PLEN_SERIAL   8'h08
`define IQR_ADD_LEN_STD   8'h1f
`define IQR_QUAL_ABSENT   8'h7f
`define IQR_SPACE         8'h20
`define IQR_STD_BYTE2     8'h01
`define IQR_STD_BYTE3     8'h02
`define IQR_STD_BYTE7     8'h9a

`define IQR_KEY_NONE      4'h0
`define IQR_KEY_ILLEGAL   4'h5
`define IQR_ASC_NONE      8'h00
`define IQR_ASC_BAD_OP    8'h20
`define IQR_ASC_BAD_FIELD 8'h24
`define IQR_ASC_CHANGED   8'h3f

`define IQR_SEL_STD       2'h0
`define IQR_SEL_LIST      2'h1
`define IQR_SEL_SERIAL    2'h2

`endif

// ---- logic/iqr_resp_rom.v ----
`include "iqr_defines.vh"
`default_nettype none

// byte of the selected response at a given index
module iqr_resp_rom (
	input  wire [1:0]   sel,
	input  wire         lun_nonzero,
	input  wire [7:0]   index,
	input  wire         medium_ready,
	input  wire         serial_valid,
	input  wire [63:0]  serial_number,
	input  wire [223:0] ident_text,
	output reg  [7:0]   byte_out
);

	wire [7:0] qual_byte;
	wire [7:0] ser_idx;
	wire [7:0] id_idx;

	assign qual_byte = lun_nonzero ? `IQR_QUAL_ABSENT : 8'h00;
	assign ser_idx   = 8'h0b - index;
	assign id_idx    = 8'h23 - index;

	always @* begin
		byte_out = 8'h00;
		case (sel)
		`IQR_SEL_LIST: begin
			case (index)
			8'h00: byte_out = qual_byte;
			8'h01: byte_out = `IQR_PAGE_LIST;
			8'h03: byte_out = `IQR_PLEN_LIST;
			8'h04: byte_out = `IQR_PAGE_LIST;
			8'h05: byte_out = `IQR_PAGE_SERIAL;
			default: byte_out = 8'h00;
			endcase
		end
		`IQR_SEL_SERIAL: begin
			case (index)
			8'h00: byte_out = qual_byte;
			8'h01: byte_out = `IQR_PAGE_SERIAL;
			8'h02: byte_out = 8'h00;
			8'h03: byte_out = `IQR_PLEN_SERIAL;
			default: begin
				// least significant character sits in byte 11
				if (serial_valid && medium_ready) begin
					byte_out = serial_number[ser_idx[2:0]*8 +: 8];
				end else begin
					byte_out = `IQR_SPACE;
				end
			end
			endcase
		end
		default: begin
			case (index)
			8'h00: byte_out = qual_byte;
			8'h02: byte_out = `IQR_STD_BYTE2;
			8'h03: byte_out = `IQR_STD_BYTE3;
			8'h04: byte_out = `IQR_ADD_LEN_STD;
			8'h07: byte_out = `IQR_STD_BYTE7;
			default: begin
				if (index >= 8'h08) begin
					// text held on the medium reads as spaces until ready
					if (medium_ready) begin
						byte_out = ident_text[id_idx[4:0]*8 +: 8];
					end else begin
						byte_out = `IQR_SPACE;
					end
				end
			end
			endcase
		end
		endcase
	end

endmodule
`default_nettype wire

// ---- logic/iqr_responder.v ----
// Our own choices: the APB interface to the registers and the register addresses.
`include "iqr_defines.vh"
`default_nettype none

module iqr_responder (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         psel,
	input  wire         penable,
	input  wire         pwrite,
	input  wire [7:0]   paddr,
	input  wire [31:0]  pwdata,
	output reg  [31:0]  prdata,
	output wire         pready,
	output wire         pslverr,
	input  wire         medium_ready,
	input  wire         serial_valid,
	input  wire [63:0]  serial_number,
	input  wire [223:0] ident_text,
	input  wire         inquiry_changed,
	output reg  [7:0]   data_in_byte,
	output reg          data_in_valid,
	input  wire         data_in_ready,
	output wire         irq
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_XFER = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	reg  [2:0]  state;
	reg  [31:0] cdb_lo;
	reg  [15:0] cdb_hi;
	reg  [1:0]  sel;
	reg         lun_nonzero;
	reg  [7:0]  xfer_len;
	reg  [7:0]  idx;
	reg         check;
	reg  [3:0]  sense_key;
	reg  [7:0]  sense_asc;
	reg         ua_pending;
	reg  [`IQR_IRQ_W-1:0] irq_stat;
	reg  [`IQR_IRQ_W-1:0] irq_mask;

	wire        wr_en;
	wire        rd_setup;
	wire        busy;
	wire        mapped;
	wire        start;
	wire        ua_clr;
	wire [7:0]  op_code;
	wire [7:0]  cdb_flags;
	wire [7:0]  page_code;
	wire [7:0]  alloc_len;
	wire        vital_data_select;
	wire        bad_op;
	wire        bad_field;
	wire [1:0]  next_sel;
	wire [7:0]  resp_len;
	wire [7:0]  next_len;
	wire        beat;
	wire        last_beat;
	wire [7:0]  rom_idx;
	wire [1:0]  rom_sel;
	wire        rom_lun;
	wire [7:0]  rom_byte;
	wire [7:0]  last_idx;
	wire [7:0]  status_asc;
	wire [31:0] status_word;
	wire [31:0] xfer_word;
	reg  [31:0] rd_word;
	reg  [`IQR_IRQ_W-1:0] irq_set;

	function [7:0] min8;
		input [7:0] a;
		input [7:0] b;
		begin
			min8 = (a < b) ? a : b;
		end
	endfunction

	// the command names a logical unit other than zero
	function lun_absent;
		input [7:0] flags;
		begin
			lun_absent = (flags[7:5] != 3'h0);
		end
	endfunction

	// offsets that hold a register; everything else answers with an error
	function reg_mapped;
		input [7:0] addr;
		begin
			case (addr)
			`IQR_OFF_CTRL,
			`IQR_OFF_CDB_LO,
			`IQR_OFF_CDB_HI,
			`IQR_OFF_STATUS,
			`IQR_OFF_IRQ_STAT,
			`IQR_OFF_IRQ_MASK,
			`IQR_OFF_XFER_LEN: reg_mapped = 1'b1;
			default:           reg_mapped = 1'b0;
			endcase
		end
	endfunction

	// apb slave: zero wait states, error on unmapped offsets
	assign pready  = 1'b1;
	assign wr_en    = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign mapped   = reg_mapped(paddr);
	assign pslverr = psel & penable & ~mapped;

	assign start  = wr_en && (paddr == `IQR_OFF_CTRL) && pwdata[`IQR_CTRL_START];
	assign ua_clr = wr_en && (paddr == `IQR_OFF_CTRL) && pwdata[`IQR_CTRL_UA_CLR];

	// command block fields
	assign op_code           = cdb_lo[7:0];
	assign cdb_flags         = cdb_lo[15:8];
	assign vital_data_select = cdb_flags[0];
	assign page_code         = cdb_lo[23:16];
	assign alloc_len         = cdb_hi[7:0];

	// only a malformed request ends in check condition, never unit attention
	assign bad_op    = (op_code != `IQR_OPCODE);
	assign bad_field = vital_data_select ?
		((page_code != `IQR_PAGE_LIST) && (page_code != `IQR_PAGE_SERIAL)) :
		(page_code != 8'h00);
	assign next_sel  = ~vital_data_select ? `IQR_SEL_STD :
		((page_code == `IQR_PAGE_SERIAL) ? `IQR_SEL_SERIAL : `IQR_SEL_LIST);
	assign resp_len  = (next_sel == `IQR_SEL_STD) ? `IQR_LEN_STD :
		((next_sel == `IQR_SEL_SERIAL) ? `IQR_LEN_SERIAL : `IQR_LEN_LIST);
	assign next_len  = min8(alloc_len, resp_len);

	assign beat      = data_in_valid & data_in_ready;
	// index of the final byte, meaningful only while transferring
	assign last_idx  = xfer_len - 8'h01;
	assign last_beat = beat && (idx == last_idx);

	// at start the rom looks at the new command, later at the next byte
	assign rom_sel = (state == ST_XFER) ? sel : next_sel;
	assign rom_lun = (state == ST_XFER) ? lun_nonzero : lun_absent(cdb_flags);
	assign rom_idx = (state == ST_XFER) ? (idx + 8'h01) : 8'h00;

	iqr_resp_rom u_rom (
		.sel           (rom_sel),
		.lun_nonzero   (rom_lun),
		.index         (rom_idx),
		.medium_ready  (medium_ready),
		.serial_valid  (serial_valid),
		.serial_number (serial_number),
		.ident_text    (ident_text),
		.byte_out      (rom_byte)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cdb_lo   <= 32'h0000_0000;
			cdb_hi   <= 16'h0000;
			irq_mask <= {`IQR_IRQ_W{1'b0}};
		end else if (wr_en) begin
			if (paddr == `IQR_OFF_CDB_LO) begin
				cdb_lo <= pwdata;
			end
			if (paddr == `IQR_OFF_CDB_HI) begin
				cdb_hi <= pwdata[15:0];
			end
			if (paddr == `IQR_OFF_IRQ_MASK) begin
				irq_mask <= pwdata[`IQR_IRQ_W-1:0];
			end
		end
	end

	// command sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state         <= ST_IDLE;
			sel           <= `IQR_SEL_STD;
			lun_nonzero   <= 1'b0;
			xfer_len      <= 8'h00;
			idx           <= 8'h00;
			check         <= 1'b0;
			sense_key     <= `IQR_KEY_NONE;
			sense_asc     <= `IQR_ASC_NONE;
			data_in_byte  <= 8'h00;
			data_in_valid <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				if (start) begin
					sel         <= next_sel;
					lun_nonzero <= lun_absent(cdb_flags);
					idx         <= 8'h00;
					if (bad_op) begin
						check     <= 1'b1;
						sense_key <= `IQR_KEY_ILLEGAL;
						sense_asc <= `IQR_ASC_BAD_OP;
						xfer_len  <= 8'h00;
						state     <= ST_DONE;
					end else if (bad_field) begin
						check     <= 1'b1;
						sense_key <= `IQR_KEY_ILLEGAL;
						sense_asc <= `IQR_ASC_BAD_FIELD;
						xfer_len  <= 8'h00;
						state     <= ST_DONE;
					end else begin
						// pending unit attention does not block the data
						check     <= 1'b0;
						sense_key <= `IQR_KEY_NONE;
						sense_asc <= `IQR_ASC_NONE;
						xfer_len  <= next_len;
						if (next_len == 8'h00) begin
							state <= ST_DONE;
						end else begin
							data_in_byte  <= rom_byte;
							data_in_valid <= 1'b1;
							state         <= ST_XFER;
						end
					end
				end
			end
			ST_XFER: begin
				if (last_beat) begin
					data_in_valid <= 1'b0;
					state         <= ST_DONE;
				end else if (beat) begin
					idx          <= idx + 8'h01;
					data_in_byte <= rom_byte;
				end
			end
			ST_DONE: begin
				state <= ST_IDLE;
			end
			default: begin
				state         <= ST_IDLE;
				data_in_valid <= 1'b0;
			end
			endcase
		end
	end

	// unit attention: raised by a data change, only software clears it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ua_pending <= 1'b0;
		end else if (inquiry_changed) begin
			ua_pending <= 1'b1;
		end else if (ua_clr) begin
			ua_pending <= 1'b0;
		end
	end

	always @* begin
		irq_set = {`IQR_IRQ_W{1'b0}};
		irq_set[`IQR_IRQ_DONE]  = (state == ST_DONE);
		irq_set[`IQR_IRQ_CHECK] = (state == ST_DONE) && check;
		irq_set[`IQR_IRQ_UA]    = inquiry_changed;
	end

	// sticky, write one to clear; a same-cycle event wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= {`IQR_IRQ_W{1'b0}};
		end else if (wr_en && (paddr == `IQR_OFF_IRQ_STAT)) begin
			irq_stat <= (irq_stat & ~pwdata[`IQR_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	assign irq = |(irq_stat & irq_mask);

	// sense reads as target conditions changed while unit attention is pending
	assign status_asc  = ua_pending ? `IQR_ASC_CHANGED : sense_asc;
	assign busy        = (state != ST_IDLE);
	assign status_word = {8'h00, status_asc, 4'h0, sense_key,
		4'h0, ua_pending, check, busy, 1'b0};
	assign xfer_word   = {16'h0000, idx, xfer_len};

	always @* begin
		rd_word = 32'h0000_0000;
		case (paddr)
		`IQR_OFF_CDB_LO:   rd_word = cdb_lo;
		`IQR_OFF_CDB_HI:   rd_word = {16'h0000, cdb_hi};
		`IQR_OFF_STATUS:   rd_word = status_word;
		`IQR_OFF_IRQ_STAT: rd_word = {{(32-`IQR_IRQ_W){1'b0}}, irq_stat};
		`IQR_OFF_IRQ_MASK: rd_word = {{(32-`IQR_IRQ_W){1'b0}}, irq_mask};
		`IQR_OFF_XFER_LEN: rd_word = xfer_word;
		default:           rd_word = 32'h0000_0000;
		endcase
	end

	// read data is taken at the setup edge and stands through the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= rd_word;
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

endmodule
`default_nettype wire

// ---- verification/iqr_chk.sv ----
`default_nettype none

module iqr_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  data_in_byte,
	input wire logic        data_in_valid,
	input wire logic        data_in_ready,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] taken;
	logic       start_q;
	logic       wr_q;
	wire        start = psel && penable && pwrite && paddr == 8'h00 && pwdata[0];
	// bytes accepted since the last start
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			taken <= 8'h00;
			start_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			start_q <= start;
			wr_q <= psel && penable && pwrite;
			if (start)
				taken <= 8'h00;
			else if (data_in_valid && data_in_ready)
				taken <= taken + 8'h01;
		end
	end
	pready_high_a: assert property (pready)
		else $error("pready low");
	byte_hold_a: assert property (data_in_valid && !data_in_ready |=>
		data_in_valid && $stable(data_in_byte))
		else $error("offered byte withdrawn");
	byte_count_a: assert property (taken <= 8'h24)
		else $error("too many bytes");
	data_launch_a: assert property ($rose(data_in_valid) |-> start_q)
		else $error("data without start");
	first_byte_a: assert property ($rose(data_in_valid) |->
		data_in_byte inside {8'h00, 8'h7f})
		else $error("bad first byte");
	rdata_idle_a: assert property (!(psel && penable) |-> prdata == 32'h0)
		else $error("read data outside access");
	slverr_access_a: assert property (pslverr |-> psel && penable)
		else $error("stray slave error");
	irq_fall_a: assert property ($fell(irq) |-> wr_q)
		else $error("irq fell without write");
	cover property (data_in_valid && !data_in_ready);
	cover property ($fell(irq));
	cover property (pslverr);
endmodule

`default_nettype wire

// ---- verification/iqr_initiator.sv ----
`default_nettype none

module iqr_initiator (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic [7:0] data_in_byte,
	input wire logic       data_in_valid,
	input wire logic       stall,
	output var logic       data_in_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx[$];
	// a byte moves only on an edge where valid and ready meet; stall halves the rate
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data_in_ready <= 1'b0;
		else begin
			if (data_in_valid && data_in_ready)
				rx.push_back(data_in_byte);
			data_in_ready <= stall ? !data_in_ready : 1'b1;
		end
	end
endmodule

`default_nettype wire

// ---- verification/iqr_responder_tb.sv ----
`default_nettype none

module iqr_responder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]   paddr, data_in_byte;
	logic [31:0]  pwdata, prdata;
	logic         medium_ready, serial_valid, inquiry_changed;
	logic         data_in_valid, data_in_ready, irq, stall, last_err;
	logic [63:0]  serial_number;
	logic [223:0] ident_text;
	int           bad_count = 0;
	int           compares = 0;

	iqr_responder u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .medium_ready, .serial_valid, .serial_number,
		.ident_text, .inquiry_changed, .data_in_byte, .data_in_valid, .data_in_ready, .irq);
	iqr_initiator u_ini (.pclk, .presetn, .data_in_byte, .data_in_valid, .stall,
		.data_in_ready);

	always #4 pclk = ~pclk;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic by(input int k, input logic [7:0] e);
		chk({24'h0, u_ini.rx[k]}, {24'h0, e});
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// load the block, start it, poll until idle and judge the sense
	task automatic inq(input logic [31:0] lo, input logic [7:0] al, input logic [31:0] est);
		logic [31:0] r;
		u_ini.rx.delete();
		apb(1'b1, 8'h04, lo, r);
		apb(1'b1, 8'h08, {24'h0, al}, r);
		apb(1'b1, 8'h00, 32'h1, r);
		r = 32'h2;
		for (int i = 0; i < 100 && r[1]; i++)
			apb(1'b0, 8'h0c, 32'h0, r);
		chk(r & 32'h00ff0f06, est);
	endtask

	task automatic t_std;
		inq(32'h0012, 8'd40, 32'h0);
		chk(u_ini.rx.size(), 36);
		by(0, 8'h00);
		by(4, 8'h1f);
		by(8, 8'h41);
		by(35, 8'h5a);
		$display("standard data test done");
	endtask

	task automatic t_pages;
		logic [31:0] r;
		inq(32'h0112, 8'd4, 32'h0);
		chk(u_ini.rx.size(), 4);
		by(3, 8'h02);
		apb(1'b0, 8'h18, 32'h0, r);
		chk(r & 32'hff, 32'h4);
		inq(32'h6112, 8'd255, 32'h0);
		chk(u_ini.rx.size(), 6);
		by(0, 8'h7f);
		by(4, 8'h00);
		by(5, 8'h80);
		$display("page list test done");
	endtask

	task automatic t_serial;
		stall <= 1'b1;
		inq(32'h800112, 8'd12, 32'h0);
		chk(u_ini.rx.size(), 12);
		by(1, 8'h80);
		by(3, 8'h08);
		by(11, 8'h38);
		serial_valid <= 1'b0;
		inq(32'h800112, 8'd11, 32'h0);
		chk(u_ini.rx.size(), 11);
		by(3, 8'h08);
		by(10, 8'h20);
		stall <= 1'b0;
		$display("serial page test done");
	endtask

	task automatic t_err;
		logic [31:0] c[4] = '{32'h800012, 32'h830112, 32'h0013, 32'h0012};
		logic [31:0] s[4] = '{32'h240504, 32'h240504, 32'h200504, 32'h0};
		logic [7:0]  a[4] = '{8'd36, 8'd36, 8'd36, 8'd0};
		logic [31:0] r;
		for (int i = 0; i < 4; i++) begin
			inq(c[i], a[i], s[i]);
			chk(u_ini.rx.size(), 0);
		end
		apb(1'b0, 8'h10, 32'h0, r);
		chk(r & 32'h3, 32'h3);
		$display("error and empty test done");
	endtask

	task automatic t_ua;
		logic [31:0] r;
		apb(1'b1, 8'h10, 32'h7, r);
		apb(1'b1, 8'h14, 32'h7, r);
		chk({31'h0, irq}, 32'h0);
		inquiry_changed <= 1'b1;
		@(posedge pclk);
		inquiry_changed <= 1'b0;
		@(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 8'h14, 32'h0, r);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, 8'h0c, 32'h0, r);
		chk(r & 32'h00ff0008, 32'h3f0008);
		medium_ready <= 1'b0;
		inq(32'h0012, 8'd36, 32'h3f0000);
		by(8, 8'h20);
		apb(1'b0, 8'h0c, 32'h0, r);
		chk(r & 32'h8, 32'h8);
		apb(1'b1, 8'h00, 32'h2, r);
		apb(1'b1, 8'h10, 32'h7, r);
		apb(1'b0, 8'h10, 32'h0, r);
		chk(r, 32'h0);
		apb(1'b0, 8'h20, 32'h0, r);
		chk({31'h0, last_err}, 32'h1);
		chk(r, 32'h0);
		medium_ready <= 1'b1;
		$display("unit attention test done");
	endtask

	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, inquiry_changed, stall} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{medium_ready, serial_valid} = 2'h3;
		serial_number = 64'h3132333435363738;
		ident_text = {8'h41, {26{8'h2e}}, 8'h5a};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_std;
		t_pages;
		t_serial;
		t_err;
		t_ua;
		finish_test;
	end

	initial begin
		#200000;
		bad_count++;
		finish_test;
	end
endmodule

bind iqr_responder iqr_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .data_in_byte, .data_in_valid, .data_in_ready, .irq);

`default_nettype wire
